// ===== rtl/cmp_vref_ctrl.sv
// comparator and ladder reference control with AXI4-Lite register access
//
// Contract
// RULE1: result bits 7:6 of comparator_control are read-only; writes do not touch them
// RULE2: mode 110 routes each raw comparator result to out_pin_a and out_pin_b
// RULE3: port_a_direction still enables the drivers of those pins in that mode
// RULE4: port data reads return zero on pins configured as analog inputs
// RULE5: comparator_irq_flag, bit 6 of peripheral_flags, sets on any result change
// RULE6: software writing zero clears the flag; writing one sets it
// RULE7: request reaches core only with flag enable, peripheral and global enables set
// RULE8: while results differ from latched values, the flag keeps being set
// RULE9: any access of comparator_control latches results and ends the mismatch
// RULE10: a change during a control read may miss the flag; here it never does
// RULE11: comparators run during sleep; enabled change interrupt wakes the device
// RULE12: mode 111 powers both comparators off
// RULE13: waking from sleep leaves comparator_control unchanged
// RULE14: reset clears comparator_control to zero, mode 000, pins analog, comparators off
// RULE15: reference bits: 7 power, 6 pin output, 5 low range, 4 reads zero
// RULE16: four-bit value picks tap: low v/24, high 1/4 plus v/32 of supply
// RULE17: reset clears reference_control to zero
// RULE18: waking from sleep leaves reference_control unchanged
// RULE19: reference reaches its pin only with direction bit 2 and output enable set
// RULE20: reference control is independent of comparator_mode
// RULE21: mode 010 applies internal reference to both positive inputs
// RULE22: per-comparator invert bit inverts the reported result
// RULE23: raw results are synchronised before reads, mismatch and flag; pins stay raw
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cmp_vref_ctrl
    import cmp_vref_pkg::*;
(
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    // register bus
    input  wire axil_req_s  bus_req,
    output axil_rsp_s       bus_rsp,
    // analog side
    input  wire logic [1:0] raw_result,
    output logic            comp_power_on,
    output logic            int_ref_to_positive,
    output logic [3:0]      comp_input_sel,
    output logic            ref_power_on,
    output logic            ref_low_range,
    output logic [3:0]      ref_value,
    output logic [6:0]      ref_level_96th,
    output logic            ref_to_pin,
    // port a pins
    input  wire logic [7:0] port_a_pin_in,
    output logic [7:0]      port_a_pin_out,
    output logic [7:0]      port_a_pin_oe,
    // core side
    input  wire logic       sleep_active,
    output logic            cmp_irq_request,
    output logic            wake_request
);
    typedef struct packed {
        logic [7:0]  comp_ctrl;
        logic [7:0]  ref_ctrl;
        logic [7:0]  port_dir;
        logic [7:0]  port_data;
        logic [7:0]  global_irq;
        logic [7:0]  periph_flags;
        logic [7:0]  periph_en;
        logic [1:0]  latched;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } ctrl_s;

    ctrl_s state_reg;
    ctrl_s state_next;

    logic [1:0] sync_result;
    logic [1:0] reported;
    logic [2:0] mode;
    logic [1:0] invert;
    logic       comp_active;
    logic [7:0] analog_mask;
    logic       wr_go;
    logic       rd_go;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    logic [7:0] wbyte;
    logic       mismatch;
    logic       comp_access;

    comp_sync u_sync (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .raw    (raw_result),
        .sync   (sync_result)
    ); // [RULE23]

    assign mode   = state_reg.comp_ctrl[2:0];
    assign invert = state_reg.comp_ctrl[5:4];
    // comparators stay powered in sleep unless the mode turns them off
    assign comp_active   = (mode != MODE_RESET) && (mode != MODE_OFF); // [RULE11] [RULE12] [RULE14]
    assign comp_power_on = comp_active;
    assign int_ref_to_positive = (mode == MODE_INT_REF); // [RULE21]
    assign comp_input_sel = state_reg.comp_ctrl[3:0];
    // off comparators report zero so a mode change does not fake a result
    assign reported = comp_active ? (sync_result ^ invert) : 2'h0; // [RULE22] [RULE23]

    always_comb begin
        case (mode)
            MODE_OFF:      analog_mask = ANALOG_NONE;
            MODE_OUT_PINS: analog_mask = ANALOG_THREE;
            default:       analog_mask = ANALOG_FOUR;
        endcase
    end

    // bus handshakes: one write and one read in flight, both gated by ce
    assign wr_go = ce && bus_req.awvalid && bus_req.wvalid && !state_reg.bvalid;
    assign rd_go = ce && bus_req.arvalid && !state_reg.rvalid;
    assign wr_idx = reg_index(bus_req.awaddr);
    assign rd_idx = reg_index(bus_req.araddr);
    assign wbyte  = bus_req.wdata[7:0];
    assign comp_access = (wr_go && wr_idx == IDX_COMP_CTRL) || (rd_go && rd_idx == IDX_COMP_CTRL);
    assign mismatch = (reported != state_reg.latched);

    always_comb begin
        state_next = state_reg;
        if (ce) begin
            if (state_reg.bvalid && bus_req.bready) begin
                state_next.bvalid = 1'b0;
            end
            if (state_reg.rvalid && bus_req.rready) begin
                state_next.rvalid = 1'b0;
            end
            if (wr_go) begin
                state_next.bvalid = 1'b1;
                state_next.bresp  = (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
                if (bus_req.wstrb[0]) begin
                    case (wr_idx)
                        IDX_COMP_CTRL: state_next.comp_ctrl = wbyte & MASK_COMP_CTRL; // [RULE1]
                        IDX_REF_CTRL: state_next.ref_ctrl = wbyte & MASK_REF_CTRL; // [RULE15] [RULE20]
                        IDX_PORT_A_DIR: state_next.port_dir = wbyte;
                        IDX_PORT_A_DATA: state_next.port_data = wbyte;
                        IDX_GLOBAL_IRQ: state_next.global_irq = wbyte;
                        IDX_PERIPH_FLAG: state_next.periph_flags = wbyte & MASK_PERIPH_FLAG; // [RULE6]
                        IDX_PERIPH_EN: state_next.periph_en = wbyte & MASK_PERIPH_EN;
                        default: state_next.periph_en = state_reg.periph_en;
                    endcase
                end
            end
            if (rd_go) begin
                state_next.rvalid = 1'b1;
                state_next.rresp  = (rd_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
                case (rd_idx)
                    IDX_COMP_CTRL: state_next.rdata = {24'h0, reported, state_reg.comp_ctrl[5:0]}; // [RULE1]
                    IDX_REF_CTRL: state_next.rdata = {24'h0, state_reg.ref_ctrl}; // [RULE15]
                    IDX_PORT_A_DIR: state_next.rdata = {24'h0, state_reg.port_dir};
                    IDX_PORT_A_DATA: state_next.rdata = {24'h0, port_a_pin_in & ~analog_mask}; // [RULE4]
                    IDX_GLOBAL_IRQ: state_next.rdata = {24'h0, state_reg.global_irq};
                    IDX_PERIPH_FLAG: state_next.rdata = {24'h0, state_reg.periph_flags};
                    IDX_PERIPH_EN: state_next.rdata = {24'h0, state_reg.periph_en};
                    default: state_next.rdata = 32'h0;
                endcase
            end
            // any comparator_control access re-arms the compare against the current results
            if (comp_access) begin
                state_next.latched = reported; // [RULE9]
            end
            // set beats a same-cycle software clear, so a change during a read is never lost
            if (mismatch) begin
                state_next.periph_flags[BIT_CMP_FLAG] = 1'b1; // [RULE5] [RULE8] [RULE10]
            end
        end
    end

    // only reset and bus writes touch the control registers; sleep and wake do not
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg              <= '0;
            state_reg.comp_ctrl    <= RST_COMP_CTRL; // [RULE14]
            state_reg.ref_ctrl     <= RST_REF_CTRL; // [RULE17]
            state_reg.port_dir     <= RST_PORT_A_DIR;
            state_reg.port_data    <= RST_PORT_A_DATA;
            state_reg.global_irq   <= RST_GLOBAL_IRQ;
            state_reg.periph_flags <= RST_PERIPH_FLAG;
            state_reg.periph_en    <= RST_PERIPH_EN;
        end else begin
            state_reg <= state_next; // [RULE13] [RULE18]
        end
    end

    assign bus_rsp.awready = wr_go;
    assign bus_rsp.wready  = wr_go;
    assign bus_rsp.bvalid  = state_reg.bvalid;
    assign bus_rsp.bresp   = state_reg.bresp;
    assign bus_rsp.arready = rd_go;
    assign bus_rsp.rvalid  = state_reg.rvalid;
    assign bus_rsp.rdata   = state_reg.rdata;
    assign bus_rsp.rresp   = state_reg.rresp;

    // reference ladder
    assign ref_power_on  = state_reg.ref_ctrl[BIT_REF_ENABLE];
    assign ref_low_range = state_reg.ref_ctrl[BIT_REF_RANGE];
    assign ref_value     = state_reg.ref_ctrl[3:0];
    assign ref_level_96th = ref_low_range ? 7'(ref_value * LADDER_LOW_STEP)
                                          : 7'(LADDER_HIGH_BASE + ref_value * LADDER_HIGH_STEP); // [RULE16]
    assign ref_to_pin = state_reg.ref_ctrl[BIT_REF_OUT_EN] && state_reg.port_dir[PIN_REF_OUT]; // [RULE19]

    // pins: raw result goes out unsynchronised, drivers still follow direction
    always_comb begin
        port_a_pin_out = state_reg.port_data;
        if (mode == MODE_OUT_PINS) begin
            port_a_pin_out[PIN_OUT_A] = raw_result[0] ^ invert[0]; // [RULE2]
            port_a_pin_out[PIN_OUT_B] = raw_result[1] ^ invert[1]; // [RULE2]
        end
    end
    assign port_a_pin_oe = ~state_reg.port_dir; // [RULE3]

    assign cmp_irq_request = state_reg.periph_flags[BIT_CMP_FLAG] && state_reg.periph_en[BIT_CMP_IRQ_EN]
                             && state_reg.global_irq[BIT_PERIPH_EN] && state_reg.global_irq[BIT_GLOBAL_EN]; // [RULE7]
    assign wake_request = sleep_active && state_reg.periph_flags[BIT_CMP_FLAG]
                          && state_reg.periph_en[BIT_CMP_IRQ_EN]; // [RULE11]

    // checks
    chk_result_readonly: assert property (@(posedge clk) disable iff (!resetn)
        (rd_go && rd_idx == IDX_COMP_CTRL) |=> (state_reg.rdata[7:6] == $past(reported))) // [RULE1]
        else $error("result bits not reported");
    chk_pin_route: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_OUT_PINS) |-> (port_a_pin_out[PIN_OUT_A] == (raw_result[0] ^ invert[0]))) // [RULE2]
        else $error("out pin a not routed");
    chk_pin_enable: assert property (@(posedge clk) disable iff (!resetn)
        port_a_pin_oe[PIN_OUT_B] == !state_reg.port_dir[PIN_OUT_B]) // [RULE3]
        else $error("out pin b enable wrong");
    chk_analog_zero: assert property (@(posedge clk) disable iff (!resetn)
        (rd_go && rd_idx == IDX_PORT_A_DATA) |=> ((state_reg.rdata[7:0] & $past(analog_mask)) == 8'h00)) // [RULE4]
        else $error("analog pin read nonzero");
    chk_flag_on_change: assert property (@(posedge clk) disable iff (!resetn)
        (ce && mismatch) |=> state_reg.periph_flags[BIT_CMP_FLAG]) // [RULE5]
        else $error("flag not set on change");
    chk_sw_clear: assert property (@(posedge clk) disable iff (!resetn)
        (wr_go && wr_idx == IDX_PERIPH_FLAG && bus_req.wstrb[0] && !wbyte[BIT_CMP_FLAG] && !mismatch)
        |=> !state_reg.periph_flags[BIT_CMP_FLAG]) // [RULE6]
        else $error("flag clear ignored");
    chk_irq_gating: assert property (@(posedge clk) disable iff (!resetn)
        cmp_irq_request |-> (state_reg.periph_en[BIT_CMP_IRQ_EN] && state_reg.global_irq[BIT_GLOBAL_EN]
                             && state_reg.global_irq[BIT_PERIPH_EN])) // [RULE7]
        else $error("irq without enables");
    chk_access_latch: assert property (@(posedge clk) disable iff (!resetn)
        (ce && comp_access) |=> (state_reg.latched == $past(reported))) // [RULE9]
        else $error("access did not latch");
    chk_mode_off: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_OFF) |-> (!comp_power_on && reported == 2'h0)) // [RULE12]
        else $error("comparators on in mode off");
    chk_ladder_level: assert property (@(posedge clk) disable iff (!resetn)
        (!ref_low_range && ref_value == 4'hf) |-> (ref_level_96th == 7'h45)) // [RULE16]
        else $error("ladder top tap wrong");
    chk_ref_bit4: assert property (@(posedge clk) disable iff (!resetn)
        (rd_go && rd_idx == IDX_REF_CTRL) |=> (state_reg.rdata[4] == 1'b0)) // [RULE15]
        else $error("reference bit 4 not zero");
    chk_ref_pin: assert property (@(posedge clk) disable iff (!resetn)
        ref_to_pin |-> (state_reg.port_dir[PIN_REF_OUT] && state_reg.ref_ctrl[BIT_REF_OUT_EN])) // [RULE19]
        else $error("reference on pin without enables");

    cov_change_flag: cover property (@(posedge clk) disable iff (!resetn) ce && mismatch);
    cov_irq_out: cover property (@(posedge clk) disable iff (!resetn) cmp_irq_request);
    cov_wake: cover property (@(posedge clk) disable iff (!resetn) wake_request);
    cov_pin_mode: cover property (@(posedge clk) disable iff (!resetn) mode == MODE_OUT_PINS);
endmodule // cmp_vref_ctrl

// ===== rtl/cmp_vref_pkg.sv
// package: register map, field layout, reset values and bus carriers for the comparator and reference block
package cmp_vref_pkg;

    localparam int ADDR_W = 12;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_GLOBAL_IRQ  = 8'h0b;
    localparam logic [7:0] IDX_PERIPH_FLAG = 8'h0c;
    localparam logic [7:0] IDX_COMP_CTRL   = 8'h1f;
    localparam logic [7:0] IDX_PORT_A_DIR  = 8'h85;
    localparam logic [7:0] IDX_PERIPH_EN   = 8'h8c;
    localparam logic [7:0] IDX_REF_CTRL    = 8'h9f;
    localparam logic [7:0] IDX_PORT_A_DATA = 8'h05;
    localparam logic [7:0] IDX_NONE        = 8'hff;

    // field positions
    localparam int BIT_SECOND_RESULT = 7;
    localparam int BIT_FIRST_RESULT  = 6;
    localparam int BIT_CMP_FLAG      = 6;
    localparam int BIT_CMP_IRQ_EN    = 6;
    localparam int BIT_GLOBAL_EN     = 7;
    localparam int BIT_PERIPH_EN     = 6;
    localparam int BIT_REF_ENABLE    = 7;
    localparam int BIT_REF_OUT_EN    = 6;
    localparam int BIT_REF_RANGE     = 5;
    localparam int PIN_REF_OUT       = 2;
    localparam int PIN_OUT_A         = 3;
    localparam int PIN_OUT_B         = 4;

    // write masks: read-only or unimplemented positions are zero
    localparam logic [7:0] MASK_COMP_CTRL   = 8'h3f;
    localparam logic [7:0] MASK_REF_CTRL    = 8'hef;
    localparam logic [7:0] MASK_PERIPH_FLAG = 8'hf7;
    localparam logic [7:0] MASK_PERIPH_EN   = 8'hf7;

    // reset values
    localparam logic [7:0] RST_COMP_CTRL   = 8'h00;
    localparam logic [7:0] RST_REF_CTRL    = 8'h00;
    localparam logic [7:0] RST_PORT_A_DIR  = 8'hff;
    localparam logic [7:0] RST_PERIPH_FLAG = 8'h00;
    localparam logic [7:0] RST_PERIPH_EN   = 8'h00;
    localparam logic [7:0] RST_GLOBAL_IRQ  = 8'h00;
    localparam logic [7:0] RST_PORT_A_DATA = 8'h00;

    // comparator modes
    localparam logic [2:0] MODE_RESET     = 3'h0;
    localparam logic [2:0] MODE_INT_REF   = 3'h2;
    localparam logic [2:0] MODE_OUT_PINS  = 3'h6;
    localparam logic [2:0] MODE_OFF       = 3'h7;

    // analog pin masks per mode class
    localparam logic [7:0] ANALOG_FOUR    = 8'h0f;
    localparam logic [7:0] ANALOG_THREE   = 8'h07;
    localparam logic [7:0] ANALOG_NONE    = 8'h00;

    // ladder level in 1/96 of supply: low = v*4, high = 24 + v*3
    localparam logic [6:0] LADDER_HIGH_BASE = 7'h18;
    localparam logic [6:0] LADDER_LOW_STEP  = 7'h04;
    localparam logic [6:0] LADDER_HIGH_STEP = 7'h03;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } axil_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_s;

    // word-aligned register index, or IDX_NONE
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0) begin
            return IDX_NONE;
        end
        case (idx)
            IDX_GLOBAL_IRQ, IDX_PERIPH_FLAG, IDX_COMP_CTRL, IDX_PORT_A_DIR,
            IDX_PERIPH_EN, IDX_REF_CTRL, IDX_PORT_A_DATA: return idx;
            default: return IDX_NONE;
        endcase
    endfunction

endpackage

// ===== rtl/comp_sync.sv
// two-flop synchroniser for the raw comparator results
`timescale 1ns/1ps
module comp_sync
    import cmp_vref_pkg::*;
(
    // clock, reset and enable
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    // raw and synchronised results
    input  wire logic [1:0] raw,
    output logic      [1:0] sync
);
    typedef struct packed {
        logic [1:0] stage1;
        logic [1:0] stage2;
    } sync_s;

    sync_s state_reg;
    sync_s state_next;

    always_comb begin
        state_next = state_reg;
        if (ce) begin
            state_next.stage1 = raw;
            state_next.stage2 = state_reg.stage1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync = state_reg.stage2;
endmodule // comp_sync

// ===== sim/comp_analog_model.sv
// behavioural model of the two analog comparators and the ladder
`timescale 1ns/1ps
module comp_analog_model (
    // control from the block
    input  wire logic            comp_power_on,
    input  wire logic            int_ref_to_positive,
    input  wire logic            ref_power_on,
    input  wire logic [6:0]      ref_level_96th,
    // pin levels in 1/96 of supply
    input  wire logic [1:0][6:0] pos_level,
    input  wire logic [1:0][6:0] neg_level,
    // comparator outputs
    output logic      [1:0]      raw_result
);
    logic [6:0] ladder;

    // powered-down ladder sits at ground
    assign ladder = ref_power_on ? ref_level_96th : 7'h00;

    // powered-off comparators read low, never a stale level
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            raw_result[i] = comp_power_on && (int_ref_to_positive ? ladder : pos_level[i]) > neg_level[i];
        end
    end
endmodule // comp_analog_model

// ===== sim/comparator_vref_control_test.sv
// self-checking bench for the comparator and reference control block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module comparator_vref_control_test import cmp_vref_pkg::*;;
    logic            clk, resetn, sleep_active, ce;
    axil_req_s       req;
    axil_rsp_s       rsp;
    logic [1:0]      raw, r;
    logic [1:0][6:0] pos, neg;
    logic [7:0]      pin_in, pin_out, pin_oe, q, dir, v, cc;
    logic [3:0]      in_sel, rvalue;
    logic [6:0]      rlevel;
    logic            cpw, iref, rpw, rlow, rpin, irq, wake;
    int              error_cnt, tests_run, i, seed;
    logic [7:0]      idx_tab [6] = '{IDX_COMP_CTRL, IDX_REF_CTRL, IDX_PORT_A_DIR,
                                     IDX_PERIPH_FLAG, IDX_PERIPH_EN, IDX_GLOBAL_IRQ};
    logic [7:0]      rst_tab [6] = '{RST_COMP_CTRL, RST_REF_CTRL, RST_PORT_A_DIR,
                                     RST_PERIPH_FLAG, RST_PERIPH_EN, RST_GLOBAL_IRQ};

    cmp_vref_ctrl dut (.clk(clk), .resetn(resetn), .ce(ce), .bus_req(req), .bus_rsp(rsp),
        .raw_result(raw), .comp_power_on(cpw), .int_ref_to_positive(iref), .comp_input_sel(in_sel),
        .ref_power_on(rpw), .ref_low_range(rlow), .ref_value(rvalue), .ref_level_96th(rlevel),
        .ref_to_pin(rpin), .port_a_pin_in(pin_in), .port_a_pin_out(pin_out), .port_a_pin_oe(pin_oe),
        .sleep_active(sleep_active), .cmp_irq_request(irq), .wake_request(wake));

    comp_analog_model analog (.comp_power_on(cpw), .int_ref_to_positive(iref), .ref_power_on(rpw),
        .ref_level_96th(rlevel), .pos_level(pos), .neg_level(neg), .raw_result(raw));

    function automatic logic [6:0] lvl(input logic [7:0] c);
        return c[5] ? 7'(c[3:0]) * 7'h04 : 7'h18 + 7'(c[3:0]) * 7'h03;
    endfunction

    // reported results after inversion; ladder fixed at 8'h8a in the mode sweep
    function automatic logic [1:0] expect_res(input logic [7:0] c);
        logic [1:0] e;
        for (int k = 0; k < 2; k++) e[k] = ((c[2:0] == 3'h2) ? lvl(8'h8a) : pos[k]) > neg[k];
        return (c[2:0] == 3'h0 || c[2:0] == 3'h7) ? 2'h0 : e ^ c[5:4];
    endfunction

    // one write or one read; ready is looked at on the falling edge so it is settled
    // waits have no limit of their own: a hang is ended by the watchdog
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] rq, output logic [1:0] rr);
        @(posedge clk);
        req.awaddr  <= {2'h0, idx, 2'h0};
        req.araddr  <= {2'h0, idx, 2'h0};
        req.wdata   <= {24'h0, d};
        req.awvalid <= w;
        req.wvalid  <= w;
        req.bready  <= w;
        req.arvalid <= !w;
        req.rready  <= !w;
        @(negedge clk);
        while (!(w ? rsp.awready && rsp.wready : rsp.arready)) @(negedge clk);
        @(posedge clk);
        req.awvalid <= 1'b0;
        req.wvalid  <= 1'b0;
        req.arvalid <= 1'b0;
        @(negedge clk);
        while (!(w ? rsp.bvalid : rsp.rvalid)) @(negedge clk);
        rq = rsp.rdata[7:0];
        rr = w ? rsp.bresp : rsp.rresp;
        @(posedge clk);
        req.bready <= 1'b0;
        req.rready <= 1'b0;
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // a hang costs at most this span
    initial begin
        #200000;
        error_cnt++;
        stop_test;
    end

    initial begin
        seed = 32'h81aa;
        resetn = 1'b0;
        ce = 1'b1;
        sleep_active = 1'b0;
        pin_in = 8'hff;
        pos = '0;
        neg = '0;
        req = '0;
        req.wstrb = 4'hf;
        repeat (5) @(posedge clk);
        `CHK("power in reset", 1'b0, cpw)
        resetn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            bus(1'b0, idx_tab[i], 8'h00, q, r);
            `CHK("reset value", rst_tab[i], q)
        end
        // byte lane 0 off: answered okay, nothing written
        req.wstrb <= 4'h0;
        bus(1'b1, IDX_REF_CTRL, 8'hff, q, r);
        req.wstrb <= 4'hf;
        bus(1'b0, IDX_REF_CTRL, 8'h00, q, r);
        `CHK("strobe off", {RESP_OKAY, 8'h00}, {r, q})
        bus(1'b1, 8'h40, 8'h55, q, r);
        `CHK("unmapped write", RESP_SLVERR, r)
        bus(1'b0, 8'h40, 8'h00, q, r);
        `CHK("unmapped read", {RESP_SLVERR, 8'h00}, {r, q})
        // ladder and pin routing under random comparator modes
        for (i = 0; i < 16; i++) begin
            v = 8'($random(seed));
            dir = 8'($random(seed));
            cc = 8'($random(seed));
            bus(1'b1, IDX_PORT_A_DIR, dir, q, r);
            bus(1'b1, IDX_COMP_CTRL, cc, q, r);
            bus(1'b1, IDX_REF_CTRL, v, q, r);
            bus(1'b0, IDX_REF_CTRL, 8'h00, q, r);
            `CHK("ref readback", v & 8'hef, q)
            `CHK("ref level", lvl(v), rlevel)
            `CHK("ref decode", {v[7], v[5], v[3:0]}, {rpw, rlow, rvalue})
            `CHK("ref pin", v[6] & dir[2], rpin)
            `CHK("pin enable", ~dir, pin_oe)
        end
        bus(1'b1, IDX_REF_CTRL, 8'h8a, q, r);
        // every comparator mode, random inputs and inversion
        for (i = 0; i < 8; i++) begin
            cc = 8'($random(seed));
            v = {2'h0, (i % 7 == 0) ? 2'h0 : cc[1:0], cc[2], 3'(i)};
            pos[0] <= 7'($random(seed));
            pos[1] <= 7'($random(seed));
            neg[0] <= 7'($random(seed));
            neg[1] <= 7'($random(seed));
            bus(1'b1, IDX_COMP_CTRL, v | 8'hc0, q, r);
            repeat (4) @(posedge clk);
            bus(1'b0, IDX_COMP_CTRL, 8'h00, q, r);
            `CHK("comp control", {expect_res(v), v[5:0]}, q)
            `CHK("out pins", (i == 6) ? {3'h0, expect_res(v), 3'h0} : 8'h00, pin_out)
            bus(1'b0, IDX_PORT_A_DATA, 8'h00, q, r);
            `CHK("analog pins", (i == 7) ? 8'hff : (i == 6) ? 8'hf8 : 8'hf0, q)
            `CHK("mode decode", {i != 0 && i != 7, i == 2, v[3:0]}, {cpw, iref, in_sel})
        end
        // change flag, mismatch and its ending
        pos <= '0;
        neg <= {7'h20, 7'h20};
        bus(1'b1, IDX_COMP_CTRL, 8'h03, q, r);
        repeat (4) @(posedge clk);
        bus(1'b0, IDX_COMP_CTRL, 8'h00, q, r);
        bus(1'b1, IDX_PERIPH_FLAG, 8'h00, q, r);
        bus(1'b0, IDX_PERIPH_FLAG, 8'h00, q, r);
        `CHK("flag cleared", 8'h00, q)
        pos[0] <= 7'h40;
        repeat (4) @(posedge clk);
        bus(1'b0, IDX_PERIPH_FLAG, 8'h00, q, r);
        `CHK("flag on change", 8'h40, q)
        bus(1'b1, IDX_PERIPH_FLAG, 8'h00, q, r);
        bus(1'b0, IDX_PERIPH_FLAG, 8'h00, q, r);
        `CHK("flag kept by mismatch", 8'h40, q)
        bus(1'b0, IDX_COMP_CTRL, 8'h00, q, r);
        bus(1'b1, IDX_PERIPH_FLAG, 8'h00, q, r);
        bus(1'b0, IDX_PERIPH_FLAG, 8'h00, q, r);
        `CHK("flag after latch", 8'h00, q)
        bus(1'b1, IDX_PERIPH_FLAG, 8'h40, q, r);
        bus(1'b0, IDX_PERIPH_FLAG, 8'h00, q, r);
        `CHK("simulated interrupt", 8'h40, q)
        for (i = 0; i < 8; i++) begin
            bus(1'b1, IDX_PERIPH_EN, {1'b0, i[0], 6'h0}, q, r);
            bus(1'b1, IDX_GLOBAL_IRQ, {i[2], i[1], 6'h0}, q, r);
            sleep_active <= i[0];
            @(negedge clk);
            `CHK("irq request", i == 7, irq)
            `CHK("wake", i[0], wake)
        end
        // change while asleep wakes the core; registers survive
        sleep_active <= 1'b0;
        bus(1'b0, IDX_COMP_CTRL, 8'h00, q, r);
        bus(1'b1, IDX_PERIPH_FLAG, 8'h00, q, r);
        sleep_active <= 1'b1;
        @(negedge clk);
        `CHK("no wake yet", 1'b0, wake)
        @(posedge clk);
        pos[1] <= 7'h40;
        repeat (4) @(posedge clk);
        `CHK("wake on change", 2'h3, {wake, irq})
        sleep_active <= 1'b0;
        bus(1'b0, IDX_COMP_CTRL, 8'h00, q, r);
        `CHK("comp after wake", 8'hc3, q)
        bus(1'b0, IDX_REF_CTRL, 8'h00, q, r);
        `CHK("ref after wake", 8'h8a, q)
        // ce low freezes the synchroniser, so a change waits until ce returns
        bus(1'b1, IDX_PERIPH_FLAG, 8'h00, q, r);
        ce <= 1'b0;
        pos[0] <= 7'h00;
        repeat (6) @(posedge clk);
        `CHK("frozen by ce", 1'b0, irq)
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("flag after ce", 1'b1, irq)
        stop_test;
    end
endmodule // comparator_vref_control_test
